// ==== common/flash_selfprog_regs.svh ====
// Offsets, field positions, patterns and timing counts of the self-programming controller.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
`ifndef FLASH_SELFPROG_REGS_SVH
`define FLASH_SELFPROG_REGS_SVH

`define FSP_AW 4
`define FSP_OFS_CTRL 4'h0
`define FSP_OFS_LOCK 4'h4
`define FSP_BIT_IRQ_EN 7
`define FSP_BIT_BUSY 6
`define FSP_BIT_RSVD 5
`define FSP_BIT_REEN 4
`define FSP_BIT_LOCKSET 3
`define FSP_BIT_PAGE_WRITE_CMD 2
`define FSP_BIT_PAGE_ERASE_CMD 1
`define FSP_BIT_STORE_EN 0
`define FSP_PAT_REEN 5'h11
`define FSP_PAT_LOCKSET 5'h09
`define FSP_PAT_PAGE_WRITE_CMD 5'h05
`define FSP_PAT_PAGE_ERASE_CMD 5'h03
`define FSP_PAT_LOAD 5'h01
`define FSP_WIN_CYCLES 3'h4
`define FSP_LOAD_LAST_CNT 3'h2
`define FSP_WIN_LAST_CNT 3'h1
`define FSP_WIN_CLOSED 3'h0
`define FSP_WORDS 64
`define FSP_WORD_W 6
`define FSP_PAGE_W 9
`define FSP_WORD_LSB 1
`define FSP_WORD_MSB 6
`define FSP_PAGE_LSB 7
`define FSP_ADDR_MSB 15
`define FSP_LOCK_LSB 2
`define FSP_LOCK_MSB 5
`define FSP_LOCK_RST 4'hF
`define FSP_ERASED_WORD 16'hFFFF
`define FSP_APP_VECTOR 16'h0000
`define FSP_SEL_FUSE_LOW 2'h0
`define FSP_SEL_LOCK 2'h1
`define FSP_SEL_FUSE_EXT 2'h2
`define FSP_SEL_FUSE_HIGH 2'h3
`define FSP_LOCK_PAD 2'h3

`endif

// ==== common/flash_selfprog_pkg.sv ====
// Types of the self-programming controller.
// Assumes flash_selfprog_regs.svh is on the include path.
`include "flash_selfprog_regs.svh"

package flash_selfprog_pkg;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_ERASE,
        OP_WRITE
    } op_t;

    typedef struct packed {
        logic wait_req;
        logic [31:0] rdata;
        logic irq_en;
        logic busy;
        logic reen;
        logic lockset;
        logic page_write_cmd;
        logic page_erase_cmd;
        logic store_en;
        logic [2:0] win_cnt;
        op_t op;
        logic [`FSP_PAGE_W-1:0] page;
        logic halt;
        logic flash_start;
        logic [`FSP_LOCK_MSB-`FSP_LOCK_LSB:0] lock_bits;
        logic [7:0] load_data;
        logic load_valid;
        logic irq;
        logic [15:0] reset_vec;
        logic [15:0] buf_rd;
        logic [`FSP_WORDS-1:0][15:0] buf_mem;
    } state_t;

endpackage

// ==== core/flash_self_programming_control.sv ====
// Self-programming sequencer: command register, page buffer, erase and write
// dispatch, busy flag, lock readback and the program-ready interrupt.
// Assumes the core and the flash macro are synchronous to i_clk_sys.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Function
// - Reset vector is 0x0000 when fuse is 1, boot address when 0.
// - Ready interrupt follows enable and global flag while store enable is clear.
// - Erase or write to concurrent section sets busy flag and blocks its reads.
// - Busy clears on re-enable after completion, or when a buffer load starts.
// - Re-enable command within four cycles unblocks section, never during an operation.
// - Re-enable written during buffer loading discards all buffered words.
// - Lock-set store programs boot lock bits from low data, ignoring the rest.
// - Load within three cycles of lock-set returns lock or fuse byte.
// - Page-write store writes buffer to page from upper pointer bits.
// - Page-erase store erases page from upper pointer bits.
// - Command bits clear on completion or after four cycles without a store.
// - Operation on halting section stalls the core for its whole duration.
// - Plain store enable puts high:low data into buffer word, bit 0 ignored.
// - Store enable clears after store or timeout; held during erase or write.
// - Only five command patterns in low five bits are accepted.
// - Target page is latched at operation start.
// - Load readback uses pointer bits 1:0 to select low fuse, lock, extended fuse or high fuse byte.
// - Buffer takes words in any order, before or after erase.
// - Halting section stays readable during concurrent section erase.
// - Buffer clears after page write, re-enable command, and reset.
// - Data EEPROM write blocks self-programming and lock or fuse readback.
module flash_self_programming_control #(
    parameter logic [15:0] BOOT_VECTOR = 16'h1000,
    parameter logic [`FSP_PAGE_W-1:0] HALT_FIRST_PAGE = 9'h060
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic [`FSP_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_store_req,
    input wire logic i_load_req,
    input wire logic [15:0] i_addr_ptr,
    input wire logic [7:0] i_low_data,
    input wire logic [7:0] i_high_data,
    input wire logic i_global_irq_en,
    input wire logic i_eeprom_busy,
    input wire logic i_boot_vector_fuse,
    input wire logic [1:0] i_lock_main,
    input wire logic [7:0] i_fuse_low,
    input wire logic [7:0] i_fuse_high,
    input wire logic [7:0] i_fuse_ext,
    input wire logic i_flash_done,
    input wire logic [`FSP_WORD_W-1:0] i_buf_rd_idx,
    output logic o_flash_start,
    output logic o_flash_erase,
    output logic [`FSP_PAGE_W-1:0] o_flash_page,
    output logic [15:0] o_buf_rd_data,
    output logic [7:0] o_load_data,
    output logic o_load_valid,
    output logic o_cpu_halt,
    output logic o_section_busy_flag,
    output logic o_prog_ready_irq,
    output logic [15:0] o_reset_vector
);

    flash_selfprog_pkg::state_t st_q;
    flash_selfprog_pkg::state_t st_d;

    logic wr_ctrl;
    logic [4:0] wr_pat;
    logic [`FSP_PAGE_W-1:0] ptr_page;
    logic start_op;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic pattern_ok(input logic [4:0] pat);
        pattern_ok = (pat == `FSP_PAT_REEN) || (pat == `FSP_PAT_LOCKSET)
            || (pat == `FSP_PAT_PAGE_WRITE_CMD) || (pat == `FSP_PAT_PAGE_ERASE_CMD)
            || (pat == `FSP_PAT_LOAD);
    endfunction

    function automatic logic in_halting(input logic [`FSP_PAGE_W-1:0] page);
        in_halting = (page >= HALT_FIRST_PAGE);
    endfunction

    function automatic logic [7:0] ctrl_image(input flash_selfprog_pkg::state_t s);
        ctrl_image = 8'h00;
        ctrl_image[`FSP_BIT_IRQ_EN] = s.irq_en;
        ctrl_image[`FSP_BIT_BUSY] = s.busy;
        ctrl_image[`FSP_BIT_REEN] = s.reen;
        ctrl_image[`FSP_BIT_LOCKSET] = s.lockset;
        ctrl_image[`FSP_BIT_PAGE_WRITE_CMD] = s.page_write_cmd;
        ctrl_image[`FSP_BIT_PAGE_ERASE_CMD] = s.page_erase_cmd;
        ctrl_image[`FSP_BIT_STORE_EN] = s.store_en;
    endfunction

    function automatic logic [7:0] lock_image(input flash_selfprog_pkg::state_t s,
                                              input logic [1:0] main_lock);
        lock_image = {`FSP_LOCK_PAD, s.lock_bits, main_lock};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign wr_pat = i_avs_writedata[`FSP_BIT_REEN:`FSP_BIT_STORE_EN];
    assign wr_ctrl = i_avs_write && !st_q.wait_req && i_avs_byteenable[0]
        && (i_avs_address == `FSP_OFS_CTRL);
    assign ptr_page = i_addr_ptr[`FSP_ADDR_MSB:`FSP_PAGE_LSB];
    assign start_op = (st_q.op == flash_selfprog_pkg::OP_NONE) && st_q.store_en
        && i_store_req && !i_eeprom_busy && (st_q.page_write_cmd || st_q.page_erase_cmd);

    always_comb begin
        st_d = st_q;
        st_d.flash_start = 1'b0;
        st_d.load_valid = 1'b0;
        st_d.reset_vec = i_boot_vector_fuse ? `FSP_APP_VECTOR : BOOT_VECTOR;
        st_d.buf_rd = st_q.buf_mem[i_buf_rd_idx];
        st_d.irq = st_q.irq_en && i_global_irq_en && !st_q.store_en;

        // One wait cycle, then answer; unmapped reads give zero
        st_d.wait_req = !((i_avs_read || i_avs_write) && st_q.wait_req);
        if (i_avs_read && st_q.wait_req) begin
            unique case (i_avs_address)
                `FSP_OFS_CTRL: st_d.rdata = {24'h000000, ctrl_image(st_q)};
                `FSP_OFS_LOCK: st_d.rdata = {24'h000000, lock_image(st_q, i_lock_main)};
                default: st_d.rdata = 32'h00000000;
            endcase
        end

        if (st_q.op != flash_selfprog_pkg::OP_NONE) begin
            // Store enable held until the macro reports completion
            if (i_flash_done) begin
                if (st_q.op == flash_selfprog_pkg::OP_WRITE) begin
                    st_d.buf_mem = {`FSP_WORDS{`FSP_ERASED_WORD}};
                end
                st_d.op = flash_selfprog_pkg::OP_NONE;
                st_d.halt = 1'b0;
                st_d.page_write_cmd = 1'b0;
                st_d.page_erase_cmd = 1'b0;
                st_d.store_en = 1'b0;
                st_d.win_cnt = `FSP_WIN_CLOSED;
            end
        end else if (st_q.store_en) begin
            if (i_store_req && !i_eeprom_busy) begin
                if (st_q.page_write_cmd || st_q.page_erase_cmd) begin
                    st_d.page = ptr_page;
                    st_d.op = st_q.page_write_cmd ? flash_selfprog_pkg::OP_WRITE
                                         : flash_selfprog_pkg::OP_ERASE;
                    st_d.flash_start = 1'b1;
                    if (in_halting(ptr_page)) begin
                        st_d.halt = 1'b1;
                    end else begin
                        st_d.busy = 1'b1;
                    end
                end else begin
                    if (st_q.lockset) begin
                        // Lock bits only ever go from one to zero
                        st_d.lock_bits = st_q.lock_bits
                            & i_low_data[`FSP_LOCK_MSB:`FSP_LOCK_LSB];
                    end else if (st_q.reen) begin
                        st_d.busy = 1'b0;
                        st_d.buf_mem = {`FSP_WORDS{`FSP_ERASED_WORD}};
                    end else begin
                        st_d.buf_mem[i_addr_ptr[`FSP_WORD_MSB:`FSP_WORD_LSB]] =
                            {i_high_data, i_low_data};
                        st_d.busy = 1'b0;
                    end
                    st_d.lockset = 1'b0;
                    st_d.reen = 1'b0;
                    st_d.store_en = 1'b0;
                    st_d.win_cnt = `FSP_WIN_CLOSED;
                end
            end else if (i_load_req && st_q.lockset && !i_eeprom_busy
                         && (st_q.win_cnt >= `FSP_LOAD_LAST_CNT)) begin
                unique case (i_addr_ptr[1:0])
                    `FSP_SEL_FUSE_LOW: st_d.load_data = i_fuse_low;
                    `FSP_SEL_LOCK: st_d.load_data = lock_image(st_q, i_lock_main);
                    `FSP_SEL_FUSE_EXT: st_d.load_data = i_fuse_ext;
                    `FSP_SEL_FUSE_HIGH: st_d.load_data = i_fuse_high;
                endcase
                st_d.load_valid = 1'b1;
                st_d.lockset = 1'b0;
                st_d.store_en = 1'b0;
                st_d.win_cnt = `FSP_WIN_CLOSED;
            end else if (st_q.win_cnt == `FSP_WIN_LAST_CNT) begin
                // Window expired with no instruction
                st_d.lockset = 1'b0;
                st_d.page_write_cmd = 1'b0;
                st_d.page_erase_cmd = 1'b0;
                st_d.reen = 1'b0;
                st_d.store_en = 1'b0;
                st_d.win_cnt = `FSP_WIN_CLOSED;
            end else begin
                st_d.win_cnt = st_q.win_cnt - 3'h1;
            end
        end

        if (wr_ctrl) begin
            st_d.irq_en = i_avs_writedata[`FSP_BIT_IRQ_EN];
            // No new command while an operation runs or EEPROM is busy
            if (pattern_ok(wr_pat) && (st_q.op == flash_selfprog_pkg::OP_NONE)
                && !start_op && !i_eeprom_busy) begin
                st_d.reen = wr_pat[`FSP_BIT_REEN];
                st_d.lockset = wr_pat[`FSP_BIT_LOCKSET];
                st_d.page_write_cmd = wr_pat[`FSP_BIT_PAGE_WRITE_CMD];
                st_d.page_erase_cmd = wr_pat[`FSP_BIT_PAGE_ERASE_CMD];
                st_d.store_en = 1'b1;
                st_d.win_cnt = `FSP_WIN_CYCLES;
                if (wr_pat == `FSP_PAT_REEN) begin
                    st_d.buf_mem = {`FSP_WORDS{`FSP_ERASED_WORD}};
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st_q <= '0;
            st_q.wait_req <= 1'b1;
            st_q.op <= flash_selfprog_pkg::OP_NONE;
            st_q.lock_bits <= `FSP_LOCK_RST;
            st_q.reset_vec <= `FSP_APP_VECTOR;
            st_q.buf_rd <= `FSP_ERASED_WORD;
            st_q.buf_mem <= {`FSP_WORDS{`FSP_ERASED_WORD}};
        end else if (i_clk_en) begin
            st_q <= st_d;
        end
    end

    assign o_avs_readdata = st_q.rdata;
    assign o_avs_waitrequest = st_q.wait_req;
    assign o_flash_start = st_q.flash_start;
    assign o_flash_erase = (st_q.op == flash_selfprog_pkg::OP_ERASE);
    assign o_flash_page = st_q.page;
    assign o_buf_rd_data = st_q.buf_rd;
    assign o_load_data = st_q.load_data;
    assign o_load_valid = st_q.load_valid;
    assign o_cpu_halt = st_q.halt;
    assign o_section_busy_flag = st_q.busy;
    assign o_prog_ready_irq = st_q.irq;
    assign o_reset_vector = st_q.reset_vec;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    chk_reset_vector_sel: assert property (
        i_clk_en |=> o_reset_vector ==
            ($past(i_boot_vector_fuse) ? `FSP_APP_VECTOR : BOOT_VECTOR))
        else $error("reset vector does not follow fuse");

    chk_ready_irq_level: assert property (
        i_clk_en && st_q.irq_en && i_global_irq_en && !st_q.store_en |=> o_prog_ready_irq)
        else $error("ready interrupt missing");

    chk_busy_on_start: assert property (
        i_clk_en && start_op && !in_halting(ptr_page) |=> o_section_busy_flag && !o_cpu_halt)
        else $error("busy flag not set for concurrent section");

    chk_reserved_zero: assert property (
        i_clk_en && i_avs_read && o_avs_waitrequest && (i_avs_address == `FSP_OFS_CTRL)
        |=> o_avs_readdata[`FSP_BIT_RSVD] == 1'b0)
        else $error("reserved bit reads one");

    chk_window_expiry: assert property (
        i_clk_en && st_q.store_en && (st_q.op == flash_selfprog_pkg::OP_NONE)
        && !wr_ctrl && !i_store_req && !i_load_req && (st_q.win_cnt == `FSP_WIN_LAST_CNT)
        |=> !st_q.store_en && !st_q.page_write_cmd && !st_q.page_erase_cmd && !st_q.lockset)
        else $error("command window did not close");

    chk_halt_start: assert property (
        i_clk_en && start_op && in_halting(ptr_page) |=> o_cpu_halt && o_flash_start)
        else $error("core not halted for halting section");

    chk_page_latched: assert property (
        (st_q.op != flash_selfprog_pkg::OP_NONE) && $past(st_q.op != flash_selfprog_pkg::OP_NONE)
        |-> $stable(o_flash_page))
        else $error("target page changed during operation");

    chk_bad_pattern: assert property (
        i_clk_en && wr_ctrl && !pattern_ok(wr_pat) && !st_q.store_en |=> !st_q.store_en)
        else $error("invalid pattern accepted");

    chk_eeprom_block: assert property (
        i_clk_en && i_eeprom_busy |=> !o_flash_start && !o_load_valid)
        else $error("programming started during eeprom write");

    chk_store_en_held: assert property (
        i_clk_en && start_op |=> st_q.store_en [*2])
        else $error("store enable dropped during operation");

endmodule

// ==== bench/flash_macro_model.sv ====
// Flash macro partner: answers each start pulse with one done pulse.
// Assumes the sequencer's clock and reset; latency is set by the bench.
`timescale 1ns/1ps
module flash_macro_model (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [7:0] i_latency,
    output logic o_done
);
    logic [7:0] cnt_q;
    logic run_q;
    always_ff @(posedge i_clk_sys) begin
        o_done <= 1'b0;
        if (i_sys_rst) begin
            run_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (i_start) begin
            run_q <= 1'b1;
            cnt_q <= i_latency;
        end else if (run_q) begin
            // One done per start; a slow answer keeps the core waiting
            if (cnt_q == 8'h00) begin
                run_q <= 1'b0;
                o_done <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// ==== bench/test_flash_self_programming_control.sv ====
// Self-checking bench for the self-programming sequencer.
// Assumes the regs header on the include path and the flash macro model.
`timescale 1ns/1ps
`include "flash_selfprog_regs.svh"
module test_flash_self_programming_control;
    localparam logic [15:0] BOOT = 16'h1000;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0, wr = 1'b0, st = 1'b0, ld = 1'b0;
    logic gie = 1'b1, eeb = 1'b0, fuse = 1'b1;
    logic [31:0] wd = 32'h0;
    logic [15:0] ptr = 16'h0, d = 16'h0;
    logic [7:0] lo = 8'h00, hi = 8'h00, lat = 8'h03, fl = 8'h00, fh = 8'h00, fe = 8'h00, lk;
    logic [1:0] lm = 2'h0;
    logic [5:0] bidx = 6'h00, w = 6'h00;
    logic [31:0] rdata;
    logic [15:0] bufd, rvec;
    logic [8:0] fpage;
    logic [7:0] ldata;
    logic wrq, fstart, ferase, lval, halt, busyf, irq, done;
    int n_fail = 0, n_compared = 0, cyc = 0;
    logic [31:0] rq[$];
    logic [7:0] lq[$];

    initial begin
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    flash_self_programming_control #(.BOOT_VECTOR(BOOT), .HALT_FIRST_PAGE(9'h060)) dut_u (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wrq),
        .i_store_req(st), .i_load_req(ld), .i_addr_ptr(ptr), .i_low_data(lo),
        .i_high_data(hi), .i_global_irq_en(gie), .i_eeprom_busy(eeb),
        .i_boot_vector_fuse(fuse), .i_lock_main(lm), .i_fuse_low(fl), .i_fuse_high(fh),
        .i_fuse_ext(fe), .i_flash_done(done), .i_buf_rd_idx(bidx),
        .o_flash_start(fstart), .o_flash_erase(ferase), .o_flash_page(fpage),
        .o_buf_rd_data(bufd), .o_load_data(ldata), .o_load_valid(lval),
        .o_cpu_halt(halt), .o_section_busy_flag(busyf), .o_prog_ready_irq(irq),
        .o_reset_vector(rvec));

    flash_macro_model flash_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_start(fstart), .i_latency(lat), .o_done(done));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wt(int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    // Holds the request until waitrequest is sampled low, then idles one cycle
    task automatic bus(logic wn, logic [3:0] a, logic [7:0] v, logic [31:0] e);
        adr <= a;
        wd <= {24'h0, v};
        wr <= wn;
        rd <= !wn;
        if (!wn) rq.push_back(e);
        @(posedge i_clk_sys);
        // Ends when waitrequest is sampled low; only the bench timeout ends a stuck wait
        while (wrq !== 1'b0) @(posedge i_clk_sys);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    // Command write, then store (k=1) or load (k=2) two edges later
    task automatic cmd(logic [7:0] c, logic [15:0] p, logic [1:0] k);
        bus(1'b1, `FSP_OFS_CTRL, c, 32'h0);
        ptr <= p;
        st <= k[0];
        ld <= k[1];
        @(posedge i_clk_sys);
        st <= 1'b0;
        ld <= 1'b0;
    endtask

    task automatic bchk(logic [5:0] i, logic [15:0] e);
        bidx <= i;
        wt(3);
        chk("buffer", {16'h0, e}, {16'h0, bufd});
    endtask

    task automatic opw(logic er, logic [8:0] pg, logic hl);
        for (int k = 0; k < 20 && fstart !== 1'b1; k++) @(posedge i_clk_sys);
        chk("erase", {31'h0, er}, {31'h0, ferase});
        chk("halt", {31'h0, hl}, {31'h0, halt});
        ptr <= ~ptr;
        for (int k = 0; k < 300 && done !== 1'b1; k++) @(posedge i_clk_sys);
        chk("halt_end", {31'h0, hl}, {31'h0, halt});
        wt(2);
        chk("page", {23'h0, pg}, {23'h0, fpage});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk_sys) begin
        cyc++;
        if (rd === 1'b1 && wrq === 1'b0) chk("rdata", rq.pop_front(), rdata);
        if (lval === 1'b1) chk("ldata", {24'h0, lq.pop_front()}, {24'h0, ldata});
        if (cyc == 8000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(17));
        lm = 2'($urandom);
        fl = 8'($urandom);
        fh = 8'($urandom);
        fe = 8'($urandom);
        wt(20);
        i_sys_rst <= 1'b0;
        @(posedge i_clk_sys);
        bus(1'b0, `FSP_OFS_CTRL, 8'h00, 32'h0);
        bus(1'b0, `FSP_OFS_LOCK, 8'h00, {24'h0, 2'h3, 4'hF, lm});
        bus(1'b0, 4'h8, 8'h00, 32'h0);
        chk("vector", 32'h0, {16'h0, rvec});
        fuse <= 1'b0;
        wt(3);
        chk("vector", {16'h0, BOOT}, {16'h0, rvec});
        $display("reset test done");
        w = 6'($urandom);
        d = 16'($urandom);
        {hi, lo} <= d;
        cmd(8'h01, {9'h000, w, 1'b1}, 2'h1);
        bchk(w, d);
        lat <= 8'h03 + 8'($urandom % 40);
        cmd(8'h03, {9'h010, 7'h0B}, 2'h1);
        opw(1'b1, 9'h010, 1'b0);
        bus(1'b0, `FSP_OFS_CTRL, 8'h00, 32'h40);
        {hi, lo} <= ~d;
        cmd(8'h01, {9'h000, w + 6'h01, 1'b0}, 2'h1);
        bus(1'b0, `FSP_OFS_CTRL, 8'h00, 32'h00);
        bchk(w, d);
        bchk(w + 6'h01, ~d);
        cmd(8'h03, {9'h070, 7'h00}, 2'h1);
        opw(1'b1, 9'h070, 1'b1);
        cmd(8'h05, {9'h070, 7'h00}, 2'h1);
        opw(1'b0, 9'h070, 1'b1);
        bchk(w, 16'hFFFF);
        bus(1'b0, `FSP_OFS_CTRL, 8'h00, 32'h00);
        $display("program test done");
        lat <= 8'h50;
        cmd(8'h03, {9'h020, 7'h00}, 2'h1);
        cmd(8'h11, 16'h0000, 2'h1);
        opw(1'b1, 9'h020, 1'b0);
        bus(1'b0, `FSP_OFS_CTRL, 8'h00, 32'h40);
        cmd(8'h11, 16'h0000, 2'h1);
        bus(1'b0, `FSP_OFS_CTRL, 8'h00, 32'h00);
        cmd(8'h01, {9'h000, w, 1'b0}, 2'h1);
        cmd(8'h11, 16'h0000, 2'h0);
        bchk(w, 16'hFFFF);
        $display("reenable test done");
        foreach (lk[i]) begin
            bus(1'b1, `FSP_OFS_CTRL, 8'h07 + 8'(i * 8), 32'h0);
            bus(1'b0, `FSP_OFS_CTRL, 8'h00, 32'h00);
        end
        foreach (lk[i]) begin
            bus(1'b1, `FSP_OFS_CTRL, 8'h01 << i[1:0] | 8'h01, 32'h0);
            wt(5);
            bus(1'b0, `FSP_OFS_CTRL, 8'h00, 32'h00);
        end
        $display("window test done");
        lo <= 8'hCF;
        cmd(8'h09, 16'($urandom), 2'h1);
        bus(1'b0, `FSP_OFS_LOCK, 8'h00, {24'h0, 2'h3, 4'h3, lm});
        for (int s = 0; s < 4; s++) begin
            lk = (s == 0) ? fl : (s == 1) ? {2'h3, 4'h3, lm} : (s == 2) ? fe : fh;
            lq.push_back(lk);
            cmd(8'h09, 16'(s), 2'h2);
            wt(3);
        end
        chk("pending_loads", 32'h0, 32'(lq.size()));
        eeb <= 1'b1;
        cmd(8'h01, {9'h000, w, 1'b0}, 2'h1);
        eeb <= 1'b0;
        bchk(w, 16'hFFFF);
        bus(1'b1, `FSP_OFS_CTRL, 8'h80, 32'h0);
        wt(2);
        chk("irq", 32'h1, {31'h0, irq});
        gie <= 1'b0;
        wt(3);
        chk("irq", 32'h0, {31'h0, irq});
        $display("lock and irq test done");
        print_verdict();
    end
endmodule
